/* src/gbwe_pkg.sv */
// Constants for the general purpose pin bank with wake and management events
package gbwe_pkg;
  localparam int GBWE_SLOTS = 48;
  // Bit s = group slot ((group - 1) * 8 + bit); gaps are slots with no pin behind them
  localparam logic [GBWE_SLOTS-1:0] GBWE_PIN_VALID = 48'hff_ff_f5_df_86_ff;

  // Control register indices (byte address is four times the index)
  localparam logic [7:0] PIN_CTRL_G1_B0 = 8'h23, PIN_CTRL_G1_B1 = 8'h24, PIN_CTRL_G1_B2 = 8'h25,
    PIN_CTRL_G1_B3 = 8'h26, PIN_CTRL_G1_B4 = 8'h27, PIN_CTRL_G1_B5 = 8'h29, PIN_CTRL_G1_B6 = 8'h2a,
    PIN_CTRL_G1_B7 = 8'h2b;
  localparam logic [7:0] PIN_CTRL_G2_B1 = 8'h2c, PIN_CTRL_G2_B2 = 8'h2d, PIN_CTRL_G2_B7 = 8'h32;
  localparam logic [7:0] PIN_CTRL_G3_B0 = 8'h33, PIN_CTRL_G3_B1 = 8'h34, PIN_CTRL_G3_B2 = 8'h35,
    PIN_CTRL_G3_B3 = 8'h36, PIN_CTRL_G3_B4 = 8'h37, PIN_CTRL_G3_B6 = 8'h39, PIN_CTRL_G3_B7 = 8'h3a;
  localparam logic [7:0] PIN_CTRL_G4_B0 = 8'h3b, PIN_CTRL_G4_B2 = 8'h3d, PIN_CTRL_G4_B4 = 8'h6e,
    PIN_CTRL_G4_B5 = 8'h6f, PIN_CTRL_G4_B6 = 8'h72, PIN_CTRL_G4_B7 = 8'h73;
  localparam logic [7:0] PIN_CTRL_G5_B0 = 8'h3f, PIN_CTRL_G5_B1 = 8'h40, PIN_CTRL_G5_B2 = 8'h41,
    PIN_CTRL_G5_B3 = 8'h42, PIN_CTRL_G5_B4 = 8'h43, PIN_CTRL_G5_B5 = 8'h44, PIN_CTRL_G5_B6 = 8'h45,
    PIN_CTRL_G5_B7 = 8'h46;
  localparam logic [7:0] PIN_CTRL_G6_B0 = 8'h47, PIN_CTRL_G6_B1 = 8'h48, PIN_CTRL_G6_B2 = 8'h54,
    PIN_CTRL_G6_B3 = 8'h55, PIN_CTRL_G6_B4 = 8'h56, PIN_CTRL_G6_B5 = 8'h57, PIN_CTRL_G6_B6 = 8'h58,
    PIN_CTRL_G6_B7 = 8'h59;
  localparam logic [7:0] NO_CTRL = 8'h00;
  localparam logic [7:0] GBWE_CTRL_IDX [GBWE_SLOTS] = '{
    PIN_CTRL_G1_B0, PIN_CTRL_G1_B1, PIN_CTRL_G1_B2, PIN_CTRL_G1_B3,
    PIN_CTRL_G1_B4, PIN_CTRL_G1_B5, PIN_CTRL_G1_B6, PIN_CTRL_G1_B7,
    NO_CTRL, PIN_CTRL_G2_B1, PIN_CTRL_G2_B2, NO_CTRL, NO_CTRL, NO_CTRL, NO_CTRL, PIN_CTRL_G2_B7,
    PIN_CTRL_G3_B0, PIN_CTRL_G3_B1, PIN_CTRL_G3_B2, PIN_CTRL_G3_B3,
    PIN_CTRL_G3_B4, NO_CTRL, PIN_CTRL_G3_B6, PIN_CTRL_G3_B7,
    PIN_CTRL_G4_B0, NO_CTRL, PIN_CTRL_G4_B2, NO_CTRL,
    PIN_CTRL_G4_B4, PIN_CTRL_G4_B5, PIN_CTRL_G4_B6, PIN_CTRL_G4_B7,
    PIN_CTRL_G5_B0, PIN_CTRL_G5_B1, PIN_CTRL_G5_B2, PIN_CTRL_G5_B3,
    PIN_CTRL_G5_B4, PIN_CTRL_G5_B5, PIN_CTRL_G5_B6, PIN_CTRL_G5_B7,
    PIN_CTRL_G6_B0, PIN_CTRL_G6_B1, PIN_CTRL_G6_B2, PIN_CTRL_G6_B3,
    PIN_CTRL_G6_B4, PIN_CTRL_G6_B5, PIN_CTRL_G6_B6, PIN_CTRL_G6_B7};

  // Data register indices
  localparam logic [7:0] PIN_DATA_GROUP1 = 8'h4b, PIN_DATA_GROUP2 = 8'h4c, PIN_DATA_GROUP3 = 8'h4d,
    PIN_DATA_GROUP4 = 8'h4e, PIN_DATA_GROUP5 = 8'h4f, PIN_DATA_GROUP6 = 8'h50;

  // Event status, enable and either-edge select register indices
  localparam logic [7:0] WAKE_STATUS_REG_1 = 8'h80, WAKE_ENABLE_REG_1 = 8'h81,
    WAKE_STATUS_REG_3 = 8'h82, WAKE_ENABLE_REG_3 = 8'h83, WAKE_STATUS_REG_5 = 8'h84,
    WAKE_ENABLE_REG_5 = 8'h85, WAKE_STATUS_REG_6 = 8'h86, WAKE_ENABLE_REG_6 = 8'h87,
    MGMT_STATUS_REG_3 = 8'h88, MGMT_ENABLE_REG_3 = 8'h89, MGMT_STATUS_REG_4 = 8'h8a,
    MGMT_ENABLE_REG_4 = 8'h8b, EITHER_EDGE_TRIGGER = 8'h8c;

  // Control register fields and reset values
  localparam int CTRL_DIR_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_ALT_BIT = 2;
  localparam int CTRL_OD_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] CTRL_RESET_ALT = 8'h05;

  // Slots with special duties
  localparam int SLOT_FP_RESET = 16;
  localparam int SLOT_MGMT_OUT = 15;
  localparam int SLOT_MODEM_OD = 20;
  localparam int SLOT_KM [4] = '{9, 10, 18, 19};
  localparam int SLOT_EITHER_EDGE_TRIGGER [4] = '{9, 10, 40, 41};

  // Edge detection waits this many edges after reset for the filtered level to settle
  localparam int ARM_CYCLES = 5;

  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

/* src/gbwe_top.sv */
// Pin bank with direction, polarity and drive control, wake and management event latching
//
// Contract
// RULE_01 - Every port owns one data bit and one eight-bit control register.
// RULE_02 - Data bits sit at fixed positions in six data registers 0x4B-0x50.
// RULE_03 - Input read returns pin level, polarity applied, captured when read.
// RULE_04 - Writing data of an input port changes nothing.
// RULE_05 - Output port drives written bit, inverted when polarity says so.
// RULE_06 - Reading an output port returns last written bit.
// RULE_07 - Control bit 0: 0 output, 1 input.
// RULE_08 - Control bit 1: 0 straight, 1 inverted, both directions.
// RULE_09 - Control bit 7 picks open-drain or push-pull output.
// RULE_10 - Bit 7 also sets drive of management request alternate output.
// RULE_11 - Output ports raise no wake or management events.
// RULE_12 - Polarity picks the edge setting wake status; default rising.
// RULE_13 - Thirteen pins own wake status and enable bits in groups 1,3,5,6; the code gives these bits to fifteen pins.
// RULE_14 - Eleven pins own management status and enable bits in groups 3,4.
// RULE_15 - Four pins fire on both edges, also into wake status 1.
// RULE_16 - After reset pins are general purpose except keyboard, mouse, panel reset.
// RULE_17 - Keyboard and mouse functions make their pins bidirectional.
// RULE_18 - Modem pin drives open-drain only when output.
// RULE_19 - Event status stays set until software writes one to it.
// RULE_20 - Management request rises whenever status and enable both set.
// RULE_21 - Pin inputs are synchronised before edge detection and read capture.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps

module gbwe_sticky #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  output logic [W-1:0] q_out
);
  if (W < 1 || W > 8)
  begin : g_bad_width
    $error("gbwe_sticky width must be 1 to 8");
  end

  // A new event beats a clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      q_out <= '0;
    else
      q_out <= (q_out & ~clr_in) | set_in; // RULE_19
  end
endmodule

module gbwe_top
  import gbwe_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Pins, one per slot
  input wire logic [GBWE_SLOTS-1:0] pin_in,
  output logic [GBWE_SLOTS-1:0] pin_out,
  output logic [GBWE_SLOTS-1:0] pin_oe_out,
  // Keyboard and mouse lines: 0 keyboard data, 1 keyboard clock, 2 mouse data, 3 mouse clock
  input wire logic [3:0] kbd_mouse_drive_low_in,
  output logic [3:0] kbd_mouse_line_out,
  // Front panel reset and event requests
  output logic front_panel_reset_b_out,
  output logic mgmt_irq_group_out,
  output logic wake_event_out
);
  if (ADDR_W < 11 || ADDR_W > 32)
  begin : g_bad_addr
    $error("gbwe_top ADDR_W must be 11 to 32");
  end

  logic [7:0] ctrl_q [GBWE_SLOTS];
  logic [GBWE_SLOTS-1:0] data_q;
  logic [GBWE_SLOTS-1:0] sync1_q, sync2_q, sync3_q, lvl_q, prev_q;
  logic [ARM_CYCLES-1:0] arm_q;
  logic [GBWE_SLOTS-1:0] ev, any_edge;
  logic [GBWE_SLOTS-1:0] pin_out_d, pin_oe_d;
  logic [3:0] either_edge_trigger_sel_q;
  logic [3:0] we1_q, me4_q;
  logic [1:0] we6_q;
  logic [4:0] we3_q;
  logic [7:0] we5_q;
  logic [6:0] me3_q;
  logic [3:0] ws1, ms4;
  logic [4:0] ws3;
  logic [7:0] ws5;
  logic [1:0] ws6;
  logic [6:0] ms3;
  logic [3:0] ws1_set, ms4_set;
  logic [4:0] ws3_set;
  logic [1:0] ws6_set;
  logic [6:0] ms3_set;
  logic mgmt_q, wake_q;

  // Write channel holding state
  logic aw_held_q, w_held_q, bvalid_q, wstrb0_q;
  logic aw_hi_q;
  logic [7:0] aw_idx_q;
  logic [7:0] wdat_q;
  logic [1:0] bresp_q;
  logic wr_go, wr_en, wr_ok;
  logic [6:0] wr_hit;
  logic [7:0] wr_grp;
  logic wr_data_reg;

  // Read channel state
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [7:0] rdata_q;
  logic [7:0] ar_idx;
  logic [6:0] rd_hit;
  logic [7:0] rd_grp;
  logic [7:0] rd_val;
  logic rd_ok;
  logic [5:0] rs;

  function automatic logic [6:0] find_ctrl(input logic [7:0] idx);
    logic [6:0] r;
    r = 7'h00;
    for (int s = 0; s < GBWE_SLOTS; s++)
    begin
      if (GBWE_PIN_VALID[s] && GBWE_CTRL_IDX[s] == idx)
        r = {1'b1, 6'(s)};
    end
    return r;
  endfunction

  function automatic logic is_own_reg(input logic [7:0] idx);
    return idx >= WAKE_STATUS_REG_1 && idx <= EITHER_EDGE_TRIGGER;
  endfunction

  // Bus slave: address and data may arrive in either order, one write in flight
  assign s_axi_awready_out = !aw_held_q && !bvalid_q;
  assign s_axi_wready_out = !w_held_q && !bvalid_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out = rresp_q;
  assign s_axi_rdata_out = {24'h000000, rdata_q};

  assign wr_go = aw_held_q && w_held_q;
  assign wr_hit = find_ctrl(aw_idx_q);
  assign wr_grp = aw_idx_q - PIN_DATA_GROUP1;
  assign wr_data_reg = aw_idx_q >= PIN_DATA_GROUP1 && aw_idx_q <= PIN_DATA_GROUP6;
  assign wr_ok = !aw_hi_q && (wr_hit[6] || wr_data_reg || is_own_reg(aw_idx_q));
  // A write with byte lane 0 off is answered but stores nothing
  assign wr_en = wr_go && wr_ok && wstrb0_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
      aw_idx_q <= 8'h00;
      aw_hi_q <= 1'b0;
      wdat_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_held_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr_in[9:2];
        aw_hi_q <= |s_axi_awaddr_in[ADDR_W-1:10];
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_held_q <= 1'b1;
        wdat_q <= s_axi_wdata_in[7:0];
        wstrb0_q <= s_axi_wstrb_in[0];
      end
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? AXI_OKAY : AXI_SLVERR;
      end
      else if (bvalid_q && s_axi_bready_in)
        bvalid_q <= 1'b0;
    end
  end

  // Read answer is registered, so an input pin is captured at the edge the read is taken
  assign ar_idx = s_axi_araddr_in[9:2];
  assign rd_hit = find_ctrl(ar_idx);
  assign rd_grp = ar_idx - PIN_DATA_GROUP1;

  always_comb
  begin
    rd_val = 8'h00;
    rd_ok = 1'b1;
    rs = 6'h00;
    if (|s_axi_araddr_in[ADDR_W-1:10])
      rd_ok = 1'b0;
    else if (rd_hit[6])
      rd_val = ctrl_q[rd_hit[5:0]]; // RULE_01
    else if (ar_idx >= PIN_DATA_GROUP1 && ar_idx <= PIN_DATA_GROUP6)
    begin
      for (int b = 0; b < 8; b++)
      begin
        rs = {rd_grp[2:0], 3'(b)}; // RULE_02
        if (GBWE_PIN_VALID[rs])
        begin
          if (ctrl_q[rs][CTRL_DIR_BIT])
            rd_val[b] = lvl_q[rs] ^ ctrl_q[rs][CTRL_POL_BIT]; // RULE_03
          else
            rd_val[b] = data_q[rs]; // RULE_06
        end
      end
    end
    else
    begin
      case (ar_idx)
        WAKE_STATUS_REG_1: rd_val = {4'h0, ws1};
        WAKE_ENABLE_REG_1: rd_val = {4'h0, we1_q};
        WAKE_STATUS_REG_3: rd_val = {3'h0, ws3};
        WAKE_ENABLE_REG_3: rd_val = {3'h0, we3_q};
        WAKE_STATUS_REG_5: rd_val = ws5;
        WAKE_ENABLE_REG_5: rd_val = we5_q;
        WAKE_STATUS_REG_6: rd_val = {6'h00, ws6};
        WAKE_ENABLE_REG_6: rd_val = {6'h00, we6_q};
        MGMT_STATUS_REG_3: rd_val = {1'b0, ms3};
        MGMT_ENABLE_REG_3: rd_val = {1'b0, me3_q};
        MGMT_STATUS_REG_4: rd_val = {4'h0, ms4};
        MGMT_ENABLE_REG_4: rd_val = {4'h0, me4_q};
        EITHER_EDGE_TRIGGER: rd_val = {4'h0, either_edge_trigger_sel_q};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= AXI_OKAY;
      rdata_q <= 8'h00;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      rdata_q <= rd_val;
    end
    else if (rvalid_q && s_axi_rready_in)
      rvalid_q <= 1'b0;
  end

  // Control registers; keyboard, mouse and panel reset pins wake up in their own function
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int s = 0; s < GBWE_SLOTS; s++)
      begin
        ctrl_q[s] <= CTRL_RESET; // RULE_16
      end
      for (int j = 0; j < 4; j++)
      begin
        ctrl_q[SLOT_KM[j]] <= CTRL_RESET_ALT; // RULE_16
      end
      ctrl_q[SLOT_FP_RESET] <= CTRL_RESET_ALT; // RULE_16
    end
    else if (wr_en && wr_hit[6])
      ctrl_q[wr_hit[5:0]] <= wdat_q[7:0]; // RULE_01
  end

  // Only output ports store a written data bit
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      data_q <= '0;
    else if (wr_en && wr_data_reg)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (GBWE_PIN_VALID[{wr_grp[2:0], 3'(b)}] && !ctrl_q[{wr_grp[2:0], 3'(b)}][CTRL_DIR_BIT]) // RULE_04 RULE_07
          data_q[{wr_grp[2:0], 3'(b)}] <= wdat_q[b]; // RULE_02
      end
    end
  end

  // Enables and either-edge selection
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      we1_q <= 4'h0;
      we3_q <= 5'h00;
      we5_q <= 8'h00;
      we6_q <= 2'b00;
      me3_q <= 7'h00;
      me4_q <= 4'h0;
      either_edge_trigger_sel_q <= 4'h0;
    end
    else if (wr_en)
    begin
      case (aw_idx_q)
        WAKE_ENABLE_REG_1: we1_q <= wdat_q[3:0];
        WAKE_ENABLE_REG_3: we3_q <= wdat_q[4:0];
        WAKE_ENABLE_REG_5: we5_q <= wdat_q[7:0];
        WAKE_ENABLE_REG_6: we6_q <= wdat_q[1:0];
        MGMT_ENABLE_REG_3: me3_q <= wdat_q[6:0];
        MGMT_ENABLE_REG_4: me4_q <= wdat_q[3:0];
        EITHER_EDGE_TRIGGER: either_edge_trigger_sel_q <= wdat_q[3:0];
        default: either_edge_trigger_sel_q <= either_edge_trigger_sel_q;
      endcase
    end
  end

  // Three-stage input filter: a level counts once the second and third stages agree
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      lvl_q <= '0;
      prev_q <= '0;
      arm_q <= '0;
    end
    else
    begin
      sync1_q <= pin_in; // RULE_21
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q <= (sync2_q & sync3_q) | (lvl_q & (sync2_q | sync3_q)); // RULE_21
      prev_q <= lvl_q;
      arm_q <= {arm_q[ARM_CYCLES-2:0], 1'b1};
    end
  end

  // Edge events; the arm delay keeps a pin that is high at reset from looking like a rise
  always_comb
  begin
    for (int s = 0; s < GBWE_SLOTS; s++)
    begin
      any_edge[s] = arm_q[ARM_CYCLES-1] && GBWE_PIN_VALID[s] && ctrl_q[s][CTRL_DIR_BIT]
        && (lvl_q[s] ^ prev_q[s]); // RULE_11
      if (ctrl_q[s][CTRL_POL_BIT])
        ev[s] = any_edge[s] && !lvl_q[s]; // RULE_12
      else
        ev[s] = any_edge[s] && lvl_q[s]; // RULE_12
    end
    for (int j = 0; j < 4; j++)
    begin
      if (either_edge_trigger_sel_q[j])
        ev[SLOT_EITHER_EDGE_TRIGGER[j]] = any_edge[SLOT_EITHER_EDGE_TRIGGER[j]]; // RULE_15
    end
  end

  assign ws1_set = {any_edge[41], any_edge[40], any_edge[10], any_edge[9]}; // RULE_15
  assign ws3_set = {ev[19], ev[18], ev[15], ev[10], ev[9]}; // RULE_13
  assign ws6_set = ev[41:40]; // RULE_13
  assign ms3_set = {ev[40], ev[39], ev[38], ev[37], ev[36], ev[10], ev[9]}; // RULE_14
  assign ms4_set = {ev[41], ev[26], ev[19], ev[18]}; // RULE_14

  gbwe_sticky #(.W(4)) u_ws1 (.clk_in(clk_in), .rst_b_in(rst_b_in), .set_in(ws1_set),
    .clr_in((wr_en && aw_idx_q == WAKE_STATUS_REG_1) ? wdat_q[3:0] : 4'h0), .q_out(ws1));
  gbwe_sticky #(.W(5)) u_ws3 (.clk_in(clk_in), .rst_b_in(rst_b_in), .set_in(ws3_set),
    .clr_in((wr_en && aw_idx_q == WAKE_STATUS_REG_3) ? wdat_q[4:0] : 5'h00), .q_out(ws3));
  gbwe_sticky #(.W(8)) u_ws5 (.clk_in(clk_in), .rst_b_in(rst_b_in), .set_in(ev[39:32]),
    .clr_in((wr_en && aw_idx_q == WAKE_STATUS_REG_5) ? wdat_q[7:0] : 8'h00), .q_out(ws5));
  gbwe_sticky #(.W(2)) u_ws6 (.clk_in(clk_in), .rst_b_in(rst_b_in), .set_in(ws6_set),
    .clr_in((wr_en && aw_idx_q == WAKE_STATUS_REG_6) ? wdat_q[1:0] : 2'b00), .q_out(ws6));
  gbwe_sticky #(.W(7)) u_ms3 (.clk_in(clk_in), .rst_b_in(rst_b_in), .set_in(ms3_set),
    .clr_in((wr_en && aw_idx_q == MGMT_STATUS_REG_3) ? wdat_q[6:0] : 7'h00), .q_out(ms3));
  gbwe_sticky #(.W(4)) u_ms4 (.clk_in(clk_in), .rst_b_in(rst_b_in), .set_in(ms4_set),
    .clr_in((wr_en && aw_idx_q == MGMT_STATUS_REG_4) ? wdat_q[3:0] : 4'h0), .q_out(ms4));

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mgmt_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      mgmt_q <= |(ms3 & me3_q) || |(ms4 & me4_q); // RULE_20
      wake_q <= |(ws1 & we1_q) || |(ws3 & we3_q) || |(ws5 & we5_q) || |(ws6 & we6_q);
    end
  end

  // Pin drive: open-drain pulls low or releases, push-pull always drives
  always_comb
  begin
    logic v;
    logic od;
    v = 1'b0;
    od = 1'b0;
    pin_out_d = '0;
    pin_oe_d = '0;
    for (int s = 0; s < GBWE_SLOTS; s++)
    begin
      v = data_q[s] ^ ctrl_q[s][CTRL_POL_BIT]; // RULE_05 RULE_08
      od = ctrl_q[s][CTRL_OD_BIT] || (s == SLOT_MODEM_OD); // RULE_09 RULE_18
      if (s == SLOT_MGMT_OUT && ctrl_q[s][CTRL_ALT_BIT])
      begin
        // Polarity clear gives an active-low request
        v = mgmt_q ^ !ctrl_q[s][CTRL_POL_BIT];
        od = ctrl_q[s][CTRL_OD_BIT]; // RULE_10
        pin_out_d[s] = !od && v;
        pin_oe_d[s] = od ? !v : 1'b1;
      end
      else if (GBWE_PIN_VALID[s] && !ctrl_q[s][CTRL_DIR_BIT] && !(s == SLOT_FP_RESET && ctrl_q[s][CTRL_ALT_BIT]))
      begin
        pin_out_d[s] = !od && v; // RULE_05
        pin_oe_d[s] = od ? !v : 1'b1; // RULE_09
      end
    end
    // Keyboard and mouse function overrides GPIO drive with a shared open-drain line
    for (int j = 0; j < 4; j++)
    begin
      if (ctrl_q[SLOT_KM[j]][CTRL_ALT_BIT])
      begin
        pin_out_d[SLOT_KM[j]] = 1'b0;
        pin_oe_d[SLOT_KM[j]] = kbd_mouse_drive_low_in[j]; // RULE_17
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pin_out <= '0;
      pin_oe_out <= '0;
      kbd_mouse_line_out <= 4'hf;
      front_panel_reset_b_out <= 1'b1;
    end
    else
    begin
      pin_out <= pin_out_d;
      pin_oe_out <= pin_oe_d;
      for (int j = 0; j < 4; j++)
      begin
        kbd_mouse_line_out[j] <= ctrl_q[SLOT_KM[j]][CTRL_ALT_BIT] ? lvl_q[SLOT_KM[j]] : 1'b1; // RULE_17
      end
      front_panel_reset_b_out <= ctrl_q[SLOT_FP_RESET][CTRL_ALT_BIT] ? lvl_q[SLOT_FP_RESET] : 1'b1;
    end
  end

  assign mgmt_irq_group_out = mgmt_q;
  assign wake_event_out = wake_q;
endmodule

/* tb/gbwe_board.sv */
// Board model: resolves every pin from the bank's drive, an outside driver and a pull-up
`timescale 1ns/1ps
module gbwe_board (
  // Bank side
  input wire logic [47:0] drv_in,
  input wire logic [47:0] oe_in,
  // Board side
  input wire logic [47:0] ext_lvl_in,
  input wire logic [47:0] ext_en_in,
  output logic [47:0] lvl_out
);
  // A released open-drain line floats up to the pull-up rather than keeping its last level
  assign lvl_out = (oe_in & drv_in) | (~oe_in & (~ext_en_in | ext_lvl_in));
endmodule

/* tb/gbwe_top_asserts.sv */
// Bus timing and pin drive checks bound to the pin bank top
`timescale 1ns/1ps
module gbwe_chk
  import gbwe_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Register bus
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Pins and events
  input wire logic [GBWE_SLOTS-1:0] pin_out,
  input wire logic [GBWE_SLOTS-1:0] pin_oe_out,
  input wire logic mgmt_irq_group_out,
  input wire logic wake_event_out
);
  // Alternate functions also move slots 9, 10, 15, 18 and 19, so only the rest must wait for a write
  localparam logic [GBWE_SLOTS-1:0] SW_ONLY = GBWE_PIN_VALID & ~48'h00_00_00_0c_86_00;
  wire logic ar_hs = s_axi_arvalid_in && s_axi_arready_out;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  a_read_answer: assert property (ar_hs |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_high_refused: assert property (ar_hs && s_axi_araddr_in[ADDR_W-1:10] != '0
    |=> s_axi_rresp_out == AXI_SLVERR && s_axi_rdata_out == 32'h0) else $error("high address not refused");
  a_read_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  a_rdata_byte: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_write_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
  a_modem_od: assert property (pin_out[SLOT_MODEM_OD] == 1'b0)
    else $error("modem pin driven high");
  a_gap_quiet: assert property (((pin_out | pin_oe_out) & ~GBWE_PIN_VALID) == '0)
    else $error("gap slot driven");
  a_pin_after_write: assert property ($changed({pin_out & SW_ONLY, pin_oe_out & SW_ONLY})
    |-> $past(s_axi_bvalid_out) || $past(s_axi_bvalid_out, 2) || $past(s_axi_bvalid_out, 3))
    else $error("pin moved without a write");
  c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
  c_wake: cover property ($rose(wake_event_out));
  c_mgmt: cover property ($rose(mgmt_irq_group_out));
endmodule

bind gbwe_top gbwe_chk #(.ADDR_W(ADDR_W)) chk_u (.clk_in, .rst_b_in, .s_axi_bresp_out, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .pin_out, .pin_oe_out, .mgmt_irq_group_out,
  .wake_event_out);

/* tb/testbench.sv */
// Self-checking bench for the pin bank: register access, pin drive and event latching
`timescale 1ns/1ps
module testbench;
  import gbwe_pkg::*;
  logic clk = 0, rst_b = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdt;
  logic [3:0] ws = 0, km = 0, kml;
  logic [47:0] xl = '1, xe = 48'h01_01_00_01_00_04, pi, po, pe;
  logic awr, wrd, bv, arr, rv, mirq, wake, fpr;
  logic [1:0] bre, rre;
  int fail_count = 0, checked = 0, s;
  always #25 clk = ~clk;
  gbwe_top dut_u (.clk_in(clk), .rst_b_in(rst_b), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_bresp_out(bre), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdt),
    .s_axi_rresp_out(rre), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .pin_in(pi), .pin_out(po),
    .pin_oe_out(pe), .kbd_mouse_drive_low_in(km), .kbd_mouse_line_out(kml), .front_panel_reset_b_out(fpr),
    .mgmt_irq_group_out(mirq), .wake_event_out(wake));
  gbwe_board board_u (.drv_in(po), .oe_in(pe), .ext_lvl_in(xl), .ext_en_in(xe), .lvl_out(pi));
  task automatic tally_and_finish;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic hang;
    fail_count++;
    $display("MISMATCH bus answer expected 1 seen 0");
    tally_and_finish();
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = AXI_OKAY,
    input logic [1:0] hi = 2'b00);
    int n;
    @(posedge clk);
    awa <= {hi, i, 2'b00};
    wd <= {24'h0, d};
    ws <= 4'h1;
    awv <= 1'b1;
    wv <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
      if (bv === 1'b1 && br === 1'b1) break;
      // Ready trails valid by a cycle so the answer must hold through a wait
      br <= bv;
    end
    if (n == 20) hang();
    ck("bresp", {30'h0, er}, {30'h0, bre});
    br <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] ex, input logic [1:0] er = AXI_OKAY,
    input logic [1:0] hi = 2'b00);
    int n;
    @(posedge clk);
    ara <= {hi, i, 2'b00};
    arv <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1 && rr === 1'b1) break;
      rr <= rv;
    end
    if (n == 20) hang();
    ck("rdata", {24'h0, ex}, rdt);
    ck("rresp", {30'h0, er}, {30'h0, rre});
    rr <= 1'b0;
  endtask
  // Pin register trails the data register by one edge, so allow three
  task automatic pk(input int sl, input logic [1:0] ex);
    repeat (3) @(posedge clk);
    ck("pin drive and enable", {30'h0, ex}, {30'h0, po[sl], pe[sl]});
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    for (s = 0; s < GBWE_SLOTS; s++)
      if (GBWE_PIN_VALID[s]) rd(GBWE_CTRL_IDX[s], (s inside {9, 10, 16, 18, 19}) ? CTRL_RESET_ALT : CTRL_RESET);
    rd(8'h00, 8'h00, AXI_SLVERR, 2'b01);
    wr(PIN_CTRL_G1_B0, 8'hff, AXI_SLVERR, 2'b01);
    rd(PIN_CTRL_G1_B0, CTRL_RESET);
    wr(PIN_CTRL_G1_B0, 8'h00);
    wr(PIN_DATA_GROUP1, 8'hff);
    pk(0, 2'b11);
    ck("input enable", 32'h0, {31'h0, pe[1]});
    rd(PIN_DATA_GROUP1, 8'hff);
    wr(PIN_CTRL_G1_B0, 8'h02);
    pk(0, 2'b01);
    rd(PIN_DATA_GROUP1, 8'hff);
    wr(PIN_CTRL_G1_B0, 8'h80);
    pk(0, 2'b00);
    wr(PIN_DATA_GROUP1, 8'h00);
    pk(0, 2'b01);
    wr(PIN_CTRL_G1_B1, 8'h00);
    pk(1, 2'b01);
    wr(PIN_CTRL_G1_B2, 8'h03);
    rd(PIN_DATA_GROUP1, 8'hf8);
    xl[2] <= 1'b0;
    repeat (10) @(posedge clk);
    rd(PIN_DATA_GROUP1, 8'hfc);
    wr(PIN_CTRL_G3_B4, 8'h00);
    wr(PIN_DATA_GROUP3, 8'h10);
    pk(SLOT_MODEM_OD, 2'b00);
    wr(WAKE_ENABLE_REG_5, 8'h03);
    xl[32] <= 1'b0;
    repeat (10) @(posedge clk);
    rd(WAKE_STATUS_REG_5, 8'h00);
    xl[32] <= 1'b1;
    repeat (10) @(posedge clk);
    rd(WAKE_STATUS_REG_5, 8'h01);
    ck("wake", 32'h1, {31'h0, wake});
    wr(WAKE_STATUS_REG_5, 8'h00);
    rd(WAKE_STATUS_REG_5, 8'h01);
    wr(WAKE_STATUS_REG_5, 8'h01);
    rd(WAKE_STATUS_REG_5, 8'h00);
    ck("wake", 32'h0, {31'h0, wake});
    wr(PIN_CTRL_G5_B1, 8'h00);
    repeat (10) @(posedge clk);
    wr(PIN_DATA_GROUP5, 8'h02);
    repeat (10) @(posedge clk);
    rd(WAKE_STATUS_REG_5, 8'h00);
    wr(EITHER_EDGE_TRIGGER, 8'h04);
    wr(MGMT_ENABLE_REG_3, 8'h40);
    xl[40] <= 1'b0;
    repeat (10) @(posedge clk);
    rd(WAKE_STATUS_REG_1, 8'h04);
    rd(MGMT_STATUS_REG_3, 8'h40);
    ck("irq", 32'h1, {31'h0, mirq});
    wr(PIN_CTRL_G2_B7, 8'h84);
    pk(SLOT_MGMT_OUT, 2'b01);
    wr(MGMT_STATUS_REG_3, 8'h40);
    repeat (2) @(posedge clk);
    ck("irq", 32'h0, {31'h0, mirq});
    pk(SLOT_MGMT_OUT, 2'b00);
    km[0] <= 1'b1;
    xl[16] <= 1'b0;
    repeat (10) @(posedge clk);
    ck("kbd line", 32'h0, {31'h0, kml[0]});
    ck("panel reset", 32'h0, {31'h0, fpr});
    tally_and_finish();
  end
endmodule
